// >>> include/bgpwm_defs.svh
// timing and width constants for the background pwm generator
`ifndef BGPWM_DEFS_SVH
`define BGPWM_DEFS_SVH

`define BGPWM_PERIOD_W      8
`define BGPWM_DUTY_W        10
`define BGPWM_CHANNELS      2
`define BGPWM_PRESCALE      4
`define BGPWM_PRESCALE_W    2
`define BGPWM_PERIOD_STOP   8'h00
`define BGPWM_CNT_W         10

`endif

// >>> include/bgpwm_pkg.sv
// types for the background pwm generator
`include "bgpwm_defs.svh"

package bgpwm_pkg;

   typedef struct packed {
      logic [`BGPWM_PERIOD_W-1:0]                      period;
      logic [`BGPWM_CHANNELS-1:0][`BGPWM_DUTY_W-1:0]   duty;
   } bgpwm_cfg_t;

   typedef enum logic [1:0] {
      BGPWM_IDLE,
      BGPWM_RUN,
      BGPWM_HALT
   } bgpwm_state_t;

endpackage

// >>> hdl/bgpwm_gen.sv
// background pwm generator with one shared period timer and two outputs
`timescale 1ns/1ps
`include "bgpwm_defs.svh"

// Overview of operation
// - Once configured the outputs keep running on their own until a new configuration is written.
// - A configuration with period zero stops the outputs instead of starting a waveform.
// - The period setting is eight bits wide, 0 to 255.
// - One cycle lasts period plus one times four system clocks.
// - The high time of each cycle is duty times one system clock.
// - The duty setting is ten bits wide, 0 to 1023.
// - Both channels take their cycle from the one shared period timer.
// - The servo function shares the timer, so the two must never be active together; the code does not prevent it and only flags an overlap on timer_conflict_o.
// - Generation halts in either low-power delay state or when the program ends.
// - Outputs appear only on fixed dedicated pins, channels one and two.
// - In the low-power delay state all timers are off, suspending pwm and servo pulses.
module bgpwm_gen (
   input  wire logic                          sys_clk_i,
   input  wire logic                          rst_i,
   input  wire bgpwm_pkg::bgpwm_cfg_t         cfg_i,
   input  wire logic                          cfg_wr_i,
   input  wire logic                          nap_i,
   input  wire logic                          sleep_i,
   input  wire logic                          prog_end_i,
   input  wire logic                          servo_active_i,
   output logic                               running_o,
   output logic                               timer_conflict_o,
   output logic [`BGPWM_CHANNELS-1:0]         pwm_o
);

   // ==========================================================
   // configuration capture
   bgpwm_pkg::bgpwm_cfg_t    pend;
   bgpwm_pkg::bgpwm_cfg_t    act;
   logic                     pend_valid;
   bgpwm_pkg::bgpwm_state_t  state;
   logic [`BGPWM_CNT_W-1:0]  cnt;
   logic [`BGPWM_CNT_W-1:0]  cyc_last;
   logic                     cyc_end;
   logic                     halt_req;

   // low-power states and program end stop every timer
   assign halt_req = nap_i | sleep_i | prog_end_i;

   // clocks per cycle minus one: (period+1)*4-1
   assign cyc_last = {act.period, `BGPWM_PRESCALE_W'(`BGPWM_PRESCALE - 1)};
   assign cyc_end  = (cnt == cyc_last);

   // a write is held until the running cycle finishes
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         pend       <= '0;
         pend_valid <= 1'b0;
      end else if (cfg_wr_i) begin
         pend       <= cfg_i;
         pend_valid <= 1'b1;
      end else if (pend_valid && ((state == bgpwm_pkg::BGPWM_RUN && (halt_req || cyc_end)) ||
                                  (state == bgpwm_pkg::BGPWM_IDLE && !halt_req))) begin
         // consumed at a boundary or from idle; a halt while running drops it,
         // a write made while halted waits until idle is reached again
         pend_valid <= 1'b0;
      end
   end

   // ==========================================================
   // run control
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state <= bgpwm_pkg::BGPWM_IDLE;
         act   <= '0;
      end else begin
         case (state)
            bgpwm_pkg::BGPWM_IDLE: begin
               if (pend_valid && !cfg_wr_i && !halt_req) begin
                  act   <= pend;
                  state <= (pend.period == `BGPWM_PERIOD_STOP) ? bgpwm_pkg::BGPWM_IDLE
                                                             : bgpwm_pkg::BGPWM_RUN;
               end
            end
            bgpwm_pkg::BGPWM_RUN: begin
               if (halt_req) begin
                  state <= bgpwm_pkg::BGPWM_HALT;
               end else if (cyc_end && pend_valid && !cfg_wr_i) begin
                  act <= pend;
                  if (pend.period == `BGPWM_PERIOD_STOP) begin
                     state <= bgpwm_pkg::BGPWM_IDLE;
                  end
               end
            end
            bgpwm_pkg::BGPWM_HALT: begin
               // stays off until software configures again; old settings are dropped
               if (!halt_req) begin
                  state <= bgpwm_pkg::BGPWM_IDLE;
               end
            end
            default: begin
               state <= bgpwm_pkg::BGPWM_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // shared period timer, free running while configured
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cnt <= '0;
      end else if (state != bgpwm_pkg::BGPWM_RUN || halt_req) begin
         cnt <= '0;
      end else if (cyc_end) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   // ==========================================================
   // per-channel comparators on the common count
   genvar ch;
   generate
      for (ch = 0; ch < `BGPWM_CHANNELS; ch++) begin : g_ch
         // duty of 4*(period+1) or more just holds the pin high: undefined case
         always_ff @(posedge sys_clk_i) begin
            if (rst_i) begin
               pwm_o[ch] <= 1'b0;
            end else if (state != bgpwm_pkg::BGPWM_RUN || halt_req) begin
               pwm_o[ch] <= 1'b0;
            end else begin
               pwm_o[ch] <= (cnt < act.duty[ch]);
            end
         end
      end
   endgenerate

   // ==========================================================
   // status
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         running_o        <= 1'b0;
         timer_conflict_o <= 1'b0;
      end else begin
         running_o        <= (state == bgpwm_pkg::BGPWM_RUN) && !halt_req;
         // flags the forbidden overlap with the servo user of the timer
         timer_conflict_o <= (state == bgpwm_pkg::BGPWM_RUN) && servo_active_i;
      end
   end

endmodule

// >>> tb/bgpwm_load.sv
// load model: mark and cycle length of one channel
`timescale 1ns/1ps
module bgpwm_load (
   input  wire logic sys_clk_i,
   input  wire logic pwm_i,
   output int        mark_o,
   output int        span_o
);
   int   hi = 0;
   int   len = 0;
   logic last = 0;
   always @(posedge sys_clk_i) begin
      if (pwm_i && !last) begin
         mark_o <= hi;
         span_o <= len;
         hi = 1;
         len = 1;
      end else begin
         hi = hi + pwm_i;
         len = len + 1;
      end
      last = pwm_i;
   end
endmodule

// >>> tb/bgpwm_gen_monitor.sv
// port checks for the pwm generator
`timescale 1ns/1ps
module bgpwm_gen_monitor (
   input wire logic                  sys_clk_i,
   input wire logic                  rst_i,
   input wire bgpwm_pkg::bgpwm_cfg_t cfg_i,
   input wire logic                  cfg_wr_i,
   input wire logic                  nap_i,
   input wire logic                  sleep_i,
   input wire logic                  prog_end_i,
   input wire logic                  servo_active_i,
   input wire logic                  running_o,
   input wire logic                  timer_conflict_o,
   input wire logic [1:0]            pwm_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   wire h = nap_i | sleep_i | prog_end_i;
   // length of the current high run on channel two, saturating
   logic [10:0] hi_run;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || !pwm_o[1]) begin
         hi_run <= 11'h000;
      end else if (hi_run != 11'h7ff) begin
         hi_run <= hi_run + 11'h001;
      end
   end
   halt_off_a: assert property (h |=> pwm_o == 2'b00) else $error("halt");
   halt_run_a: assert property (h |=> !running_o) else $error("halt run");
   start_run_a: assert property (cfg_wr_i && cfg_i.period != 8'h00 && !running_o && !h && !$past(h)
      ##1 !cfg_wr_i && !h ##1 !h |=> running_o) else $error("start");
   low_gap_a: assert property ($fell(pwm_o[0]) |-> !pwm_o[0] [*4]) else $error("gap");
   mark_bound_a: assert property (hi_run < 11'h400) else $error("mark");
   conflict_src_a: assert property (timer_conflict_o |-> $past(servo_active_i)) else $error("conflict");
   rise_run_a: assert property ($rose(pwm_o[0]) |-> running_o) else $error("rise");
   idle_quiet_a: assert property (!running_o && !$past(running_o) |-> pwm_o == 2'b00) else $error("idle");
   cover property ($rose(running_o));
   cover property ($fell(running_o));
   cover property (timer_conflict_o);
endmodule
bind bgpwm_gen bgpwm_gen_monitor mon (.sys_clk_i, .rst_i, .cfg_i, .cfg_wr_i, .nap_i, .sleep_i,
   .prog_end_i, .servo_active_i, .running_o, .timer_conflict_o, .pwm_o);

// >>> tb/background_pwm_generator_test.sv
// self-checking bench for the pwm generator
`timescale 1ns/1ps
module background_pwm_generator_test;
   logic                  sys_clk_i = 0, rst_i = 1, cfg_wr_i = 0, servo_active_i = 0;
   logic [2:0]            halt = 0;
   bgpwm_pkg::bgpwm_cfg_t cfg_i = '0;
   logic                  running_o, timer_conflict_o;
   logic [1:0]            pwm_o;
   int                    errors, check_count, cyc, mark[2], span[2], p, d[2];
   bgpwm_gen dut (.sys_clk_i, .rst_i, .cfg_i, .cfg_wr_i, .nap_i(halt[0]), .sleep_i(halt[1]),
      .prog_end_i(halt[2]), .servo_active_i, .running_o, .timer_conflict_o, .pwm_o);
   bgpwm_load ld0 (.sys_clk_i, .pwm_i(pwm_o[0]), .mark_o(mark[0]), .span_o(span[0]));
   bgpwm_load ld1 (.sys_clk_i, .pwm_i(pwm_o[1]), .mark_o(mark[1]), .span_o(span[1]));
   initial forever #25 sys_clk_i = ~sys_clk_i;
   // ceiling well above the longest sequence
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         final_report();
      end
   end
   task automatic chk(input bit c);
      check_count++;
      if (!c) begin
         errors++;
         $display("[FAIL] %0t mismatch", $time);
      end
   endtask
   task automatic idle(int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   task automatic wr(int per, int a, int b);
      @(negedge sys_clk_i);
      cfg_i = {per[7:0], b[9:0], a[9:0]};
      cfg_wr_i = 1;
      @(negedge sys_clk_i) cfg_wr_i = 0;
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      void'($urandom(92010));
      idle(4);
      rst_i = 0;
      // longest period last, so the old cycle never outlasts the wait
      for (int i = 0; i < 5; i++) begin
         p = (i == 4) ? 255 : $urandom_range(15, 1);
         d[0] = $urandom_range(4 * p, 1);
         d[1] = $urandom_range(4 * p, 1);
         wr(p, d[0], d[1]);
         idle(64 + 12 * (p + 1));
         chk(span[0] == 4 * (p + 1));
         chk(span[1] == span[0]);
         chk(mark[0] == d[0] && mark[1] == d[1]);
         $display("config test %0d done", i);
      end
      servo_active_i = 1;
      idle(2);
      chk(timer_conflict_o === 1'b1);
      servo_active_i = 0;
      for (int k = 0; k < 3; k++) begin
         wr(3, 5, 7);
         idle(40);
         halt[k] = 1;
         idle(1);
         chk(pwm_o === 2'b00);
         halt[k] = 0;
         idle(40);
         chk(running_o === 1'b0 && pwm_o === 2'b00);
      end
      $display("halt test done");
      wr(3, 5, 7);
      idle(40);
      chk(running_o === 1'b1);
      wr(0, 0, 0);
      idle(40);
      chk(running_o === 1'b0 && pwm_o === 2'b00);
      $display("stop test done");
      final_report();
   end
endmodule
